/* File: shared/mctc_consts.svh */
// Constants of the instruction timing core: timing, field positions, reset values
// Included by bare name from every design file; holds definitions only
`ifndef MCTC_CONSTS_SVH
`define MCTC_CONSTS_SVH
`define MCTC_CLK_PER_ICYC 4
`define MCTC_PH_FETCH 2'h1
`define MCTC_PH_LAST 2'h3
`define MCTC_PCL_ADDR 8'h06
`define MCTC_PC_W 12
`define MCTC_STK_DEPTH 8
`define MCTC_RST_PC 12'h000
`define MCTC_F_GRP_HI 15
`define MCTC_F_GRP_LO 12
`define MCTC_F_SUB_HI 11
`define MCTC_F_SUB_LO 9
`define MCTC_F_MISC_LO 8
`define MCTC_F_DEST 8
`define MCTC_F_OPND_HI 7
`endif

/* File: shared/mctc_pkg.sv */
// Types of the instruction timing core: instruction groups, ALU operations, states
// Compiled before the interfaces and design modules
package mctc_pkg;
	typedef enum logic [3:0] {
		GRP_MISC = 4'h0, GRP_XFER_AM = 4'h1, GRP_XFER_MA = 4'h2, GRP_XFER_AX = 4'h3,
		GRP_ALU_M = 4'h4, GRP_ALU_X = 4'h5, GRP_UNARY = 4'h6, GRP_BSET = 4'h7,
		GRP_BCLR = 4'h8, GRP_SKZ = 4'h9, GRP_SKBS = 4'hA, GRP_SKBC = 4'hB,
		GRP_UBRANCH = 4'hC, GRP_CALL = 4'hD
	} mctc_grp_t;
	typedef enum logic [3:0] {
		MISC_NOP = 4'h0, MISC_SUBEXIT = 4'h1, MISC_INTEXIT = 4'h2, MISC_PDOWN = 4'h3,
		MISC_TABRD = 4'h4
	} mctc_misc_t;
	typedef enum logic [3:0] {
		ALU_ADD = 4'h0, ALU_ADC = 4'h1, ALU_SUB = 4'h2, ALU_SBC = 4'h3,
		ALU_AND = 4'h4, ALU_OR = 4'h5, ALU_XOR = 4'h6, ALU_CMPL = 4'h7,
		ALU_ADD1 = 4'h8, ALU_SUB1 = 4'h9, ALU_ROR = 4'hA, ALU_ROL = 4'hB,
		ALU_RORC = 4'hC, ALU_ROLC = 4'hD, ALU_PASS = 4'hF
	} mctc_alu_op_t;
	typedef enum logic [2:0] {
		ST_EXEC = 3'h1, ST_EXTRA = 3'h2, ST_PDN = 3'h4
	} mctc_st_t;
endpackage

/* File: shared/mctc_if.sv */
// Interfaces between the core sequencer, its ALU and its return-address stack
// The stack side runs on the core clock; the ALU side is combinational with no clock
`timescale 1ns/100ps
interface mctc_alu_if;
	import mctc_pkg::*;
	mctc_alu_op_t op;
	logic [7:0] a;
	logic [7:0] b;
	logic cin;
	logic [7:0] res;
	logic cout;
	logic zero;
	logic z_we;
	logic c_we;
	modport core (output op, a, b, cin, input res, cout, zero, z_we, c_we);
	modport alu (input op, a, b, cin, output res, cout, zero, z_we, c_we);
endinterface

interface mctc_stk_if #(parameter int PC_W = 12);
	logic push;
	logic pop;
	logic [PC_W-1:0] wdata;
	logic [PC_W-1:0] top;
	modport core (output push, pop, wdata, input top);
	modport stk (input push, pop, wdata, output top);
endinterface

/* File: design/mctc_alu.sv */
// Combinational 8-bit ALU: add, subtract, logic, increment, decrement, rotates
// Operand a is the accumulator, b the memory or immediate value; no clock
`timescale 1ns/100ps
`include "mctc_consts.svh"
module mctc_alu import mctc_pkg::*; (
	mctc_alu_if.alu f // Operands in, result and flag updates out
);
	function automatic logic [8:0] add9(input logic [7:0] x, input logic [7:0] y,
		input logic ci);
		return {1'b0, x} + {1'b0, y} + {8'h00, ci};
	endfunction

	logic [8:0] sum;
	logic [7:0] res_v;
	logic cout_v;
	logic z_we_v;
	logic c_we_v;

	always_comb begin
		sum = 9'h000;
		res_v = f.b;
		cout_v = f.cin;
		z_we_v = 1'b0;
		c_we_v = 1'b0;
		unique case (f.op)
			ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC: begin
				// Carry set above 255; after subtract a clear carry marks a borrow
				sum = add9(f.a, (f.op[1] ? ~f.b : f.b), (f.op[0] ? f.cin : f.op[1]));
				res_v = sum[7:0];
				cout_v = sum[8];
				z_we_v = 1'b1;
				c_we_v = 1'b1;
			end
			ALU_AND: begin res_v = f.a & f.b; z_we_v = 1'b1; end
			ALU_OR: begin res_v = f.a | f.b; z_we_v = 1'b1; end
			ALU_XOR: begin res_v = f.a ^ f.b; z_we_v = 1'b1; end
			ALU_CMPL: begin res_v = ~f.b; z_we_v = 1'b1; end
			ALU_ADD1: begin res_v = f.b + 8'h01; z_we_v = 1'b1; end
			ALU_SUB1: begin res_v = f.b - 8'h01; z_we_v = 1'b1; end
			ALU_ROR: res_v = {f.b[0], f.b[7:1]};
			ALU_ROL: res_v = {f.b[6:0], f.b[7]};
			ALU_RORC: begin res_v = {f.cin, f.b[7:1]}; cout_v = f.b[0]; c_we_v = 1'b1; end
			ALU_ROLC: begin res_v = {f.b[6:0], f.cin}; cout_v = f.b[7]; c_we_v = 1'b1; end
			ALU_PASS: res_v = f.b;
			default: res_v = f.b;
		endcase
	end

	assign f.res = res_v;
	assign f.cout = cout_v;
	assign f.zero = (res_v == 8'h00);
	assign f.z_we = z_we_v;
	assign f.c_we = c_we_v;
endmodule

/* File: design/mctc_stack.sv */
// Return-address stack for calls and subroutine exits
// Push and pop are single-cycle strobes from the sequencer; overflow wraps
`timescale 1ns/100ps
`include "mctc_consts.svh"
module mctc_stack #(
	parameter int PC_W = `MCTC_PC_W,
	parameter int DEPTH = `MCTC_STK_DEPTH
) (
	input wire logic clock_i, // Core clock
	input wire logic rst_n_i, // Asynchronous reset, active low
	mctc_stk_if.stk s // Push, pop and top of stack
);
	localparam int PW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][PC_W-1:0] ent;
		logic [PW-1:0] ptr;
	} mctc_stk_st_t;

	mctc_stk_st_t state_q;
	mctc_stk_st_t state_d;

	always_comb begin
		state_d = state_q;
		if (s.push) begin
			state_d.ent[state_q.ptr] = s.wdata;
			state_d.ptr = state_q.ptr + 1'b1;
		end else if (s.pop) begin
			state_d.ptr = state_q.ptr - 1'b1;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign s.top = state_q.ent[state_q.ptr - 1'b1];

	push_then_top_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		s.push |=> s.top == $past(s.wdata))
		else $error("stack top is not the value just pushed");
endmodule

/* File: design/mctc_core.sv */
// Instruction sequencer of the 8-bit core: four-phase instruction cycle, extra cycles,
// skips, calls, table reads, bit operations and power-down
// Program memory and data memory are synchronous: read data one clock after the address
`timescale 1ns/100ps
`include "mctc_consts.svh"
module mctc_core import mctc_pkg::*; #(
	parameter int PC_W = `MCTC_PC_W,
	parameter int STK_DEPTH = `MCTC_STK_DEPTH
) (
	input wire logic clock_i, // System clock, 250 MHz
	input wire logic rst_n_i, // Asynchronous reset, active low
	output logic [PC_W-1:0] pm_addr_o, // Program memory address
	input wire logic [15:0] pm_data_i, // Program memory word
	output logic [7:0] dm_addr_o, // Data memory address
	input wire logic [7:0] dm_rdata_i, // Data memory read data
	output logic [7:0] dm_wdata_o, // Data memory write data
	output logic dm_we_o, // Data memory write strobe
	input wire logic wake_i, // Wake request from power-down, asynchronous
	output logic [PC_W-1:0] pc_o, // Program counter
	output logic [7:0] acc_o, // Accumulator
	output logic zero_o, // Zero flag
	output logic carry_o, // Carry flag
	output logic gie_o, // Global interrupt enable
	output logic pdn_o, // Core is powered down
	output logic icyc_done_o // Pulse in the clock after the last clock of each instruction, except power-down
);
	typedef struct packed {
		mctc_st_t st;
		logic [1:0] ph;
		logic [1:0] extra;
		logic [15:0] ir;
		logic [PC_W-1:0] pc;
		logic [7:0] acc;
		logic z;
		logic c;
		logic gie;
		logic tbl;
		logic [PC_W-1:0] pm_addr;
		logic [7:0] dm_addr;
		logic [7:0] dm_wdata;
		logic dm_we;
		logic wake_m;
		logic wake_s;
		logic done;
	} mctc_core_st_t;

	function automatic logic is_pcl(input logic [7:0] a);
		return a == `MCTC_PCL_ADDR;
	endfunction

	function automatic logic [7:0] bit_mask(input logic [2:0] i);
		return 8'h01 << i;
	endfunction

	mctc_core_st_t state_q;
	mctc_core_st_t state_d;

	mctc_alu_if alu_bus ();
	mctc_stk_if #(.PC_W(PC_W)) stk_bus ();

	mctc_grp_t grp;
	mctc_misc_t misc;
	logic [2:0] sub;
	logic [7:0] opnd;
	logic [7:0] mval;
	logic exec_end;
	logic skip;
	logic wr_m;
	logic [7:0] wr_val;
	logic [1:0] more;
	logic [PC_W-1:0] pc_inc;
	logic add_ovf;

	assign grp = mctc_grp_t'(state_q.ir[`MCTC_F_GRP_HI:`MCTC_F_GRP_LO]);
	assign misc = mctc_misc_t'(state_q.ir[`MCTC_F_SUB_HI:`MCTC_F_MISC_LO]);
	assign sub = state_q.ir[`MCTC_F_SUB_HI:`MCTC_F_SUB_LO];
	assign opnd = state_q.ir[`MCTC_F_OPND_HI:0];
	// Reads of the low program counter byte come from the core, not from memory
	assign mval = is_pcl(state_q.dm_addr) ? state_q.pc[7:0] : dm_rdata_i;
	assign exec_end = (state_q.st == ST_EXEC) && (state_q.ph == `MCTC_PH_LAST);
	assign pc_inc = state_q.pc + PC_W'(1);
	assign add_ovf = ({1'b0, state_q.acc} + {1'b0, opnd}) > 9'h0FF;

	assign alu_bus.op = mctc_alu_op_t'({grp == GRP_UNARY, sub});
	assign alu_bus.a = state_q.acc;
	assign alu_bus.b = (grp == GRP_ALU_X) ? opnd : mval;
	assign alu_bus.cin = state_q.c;

	assign stk_bus.push = exec_end && (grp == GRP_CALL);
	assign stk_bus.pop = exec_end && (grp == GRP_MISC) &&
		(misc == MISC_SUBEXIT || misc == MISC_INTEXIT);
	assign stk_bus.wdata = pc_inc;

	mctc_alu u_alu (
		.f(alu_bus.alu)
	);

	mctc_stack #(.PC_W(PC_W), .DEPTH(STK_DEPTH)) u_stack (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.s(stk_bus.stk)
	);

	always_comb begin
		state_d = state_q;
		skip = 1'b0;
		wr_m = 1'b0;
		wr_val = 8'h00;
		more = 2'h0;
		state_d.dm_we = 1'b0;
		state_d.done = 1'b0;
		state_d.wake_m = wake_i;
		state_d.wake_s = state_q.wake_m;
		unique case (state_q.st)
			ST_EXEC: begin
				state_d.ph = state_q.ph + 2'h1;
				if (state_q.ph == `MCTC_PH_FETCH) begin
					state_d.ir = pm_data_i;
					state_d.dm_addr = pm_data_i[`MCTC_F_OPND_HI:0];
				end
				if (state_q.ph == `MCTC_PH_LAST) begin
					state_d.pc = pc_inc;
					unique case (grp)
						GRP_MISC: begin
							unique case (misc)
								MISC_SUBEXIT: begin
									state_d.pc = stk_bus.top;
									more = 2'h1;
								end
								MISC_INTEXIT: begin
									state_d.pc = stk_bus.top;
									state_d.gie = 1'b1;
									more = 2'h1;
								end
								MISC_PDOWN: state_d.st = ST_PDN;
								MISC_TABRD: begin
									state_d.tbl = 1'b1;
									more = 2'h1;
								end
								default: state_d.pc = pc_inc;
							endcase
						end
						GRP_XFER_AM: state_d.acc = mval;
						GRP_XFER_MA: begin
							wr_m = 1'b1;
							wr_val = state_q.acc;
						end
						GRP_XFER_AX: state_d.acc = opnd;
						GRP_ALU_M, GRP_UNARY, GRP_ALU_X: begin
							if (state_q.ir[`MCTC_F_DEST] && grp != GRP_ALU_X) begin
								wr_m = 1'b1;
								wr_val = alu_bus.res;
							end else begin
								state_d.acc = alu_bus.res;
							end
							if (alu_bus.z_we) begin
								state_d.z = alu_bus.zero;
							end
							if (alu_bus.c_we) begin
								state_d.c = alu_bus.cout;
							end
						end
						GRP_BSET: begin
							wr_m = 1'b1;
							wr_val = mval | bit_mask(sub);
						end
						GRP_BCLR: begin
							wr_m = 1'b1;
							wr_val = mval & ~bit_mask(sub);
						end
						GRP_SKZ: skip = state_q.ir[`MCTC_F_DEST] ^ (mval == 8'h00);
						GRP_SKBS: skip = (mval & bit_mask(sub)) != 8'h00;
						GRP_SKBC: skip = (mval & bit_mask(sub)) == 8'h00;
						GRP_UBRANCH, GRP_CALL: begin
							state_d.pc = state_q.ir[PC_W-1:0];
							more = 2'h1;
						end
						default: state_d.pc = pc_inc;
					endcase
					if (wr_m) begin
						state_d.dm_wdata = wr_val;
						state_d.dm_we = 1'b1;
						if (is_pcl(state_q.dm_addr)) begin
							state_d.pc = {state_q.pc[PC_W-1:8], wr_val};
							more = more + 2'h1;
						end
					end
					if (skip) begin
						state_d.pc = state_q.pc + PC_W'(2);
						more = 2'h1;
					end
					if (grp == GRP_MISC && misc == MISC_TABRD) begin
						state_d.pm_addr = {state_q.pc[PC_W-1:8], state_q.acc};
					end else begin
						state_d.pm_addr = state_d.pc;
					end
					if (state_d.st != ST_PDN) begin
						if (more != 2'h0) begin
							state_d.st = ST_EXTRA;
							state_d.extra = more - 2'h1;
						end else begin
							state_d.done = 1'b1;
						end
					end
				end
			end
			ST_EXTRA: begin
				state_d.ph = state_q.ph + 2'h1;
				if (state_q.ph == `MCTC_PH_LAST) begin
					if (state_q.tbl) begin
						state_d.acc = pm_data_i[7:0];
						state_d.tbl = 1'b0;
						state_d.pm_addr = state_q.pc;
					end
					if (state_q.extra == 2'h0) begin
						state_d.st = ST_EXEC;
						state_d.done = 1'b1;
					end else begin
						state_d.extra = state_q.extra - 2'h1;
					end
				end
			end
			ST_PDN: begin
				if (state_q.wake_s) begin
					state_d.st = ST_EXEC;
				end
			end
			default: state_d.st = ST_EXEC;
		endcase
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= '0;
			state_q.st <= ST_EXEC;
			state_q.pc <= PC_W'(`MCTC_RST_PC);
			state_q.pm_addr <= PC_W'(`MCTC_RST_PC);
		end else begin
			state_q <= state_d;
		end
	end

	assign pm_addr_o = state_q.pm_addr;
	assign dm_addr_o = state_q.dm_addr;
	assign dm_wdata_o = state_q.dm_wdata;
	assign dm_we_o = state_q.dm_we;
	assign pc_o = state_q.pc;
	assign acc_o = state_q.acc;
	assign zero_o = state_q.z;
	assign carry_o = state_q.c;
	assign gie_o = state_q.gie;
	assign pdn_o = state_q.st[2];
	assign icyc_done_o = state_q.done;

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_n_i);

	icyc_four_clk_a: assert property (
		(state_q.st == ST_EXEC && state_q.ph == 2'h0) |->
		##3 (state_q.st == ST_EXEC && state_q.ph == 2'h3))
		else $error("instruction cycle is not four clocks");
	single_cycle_a: assert property (
		(exec_end && grp == GRP_XFER_AX) |=> (state_q.st == ST_EXEC && state_q.ph == 2'h0))
		else $error("ordinary instruction took an extra cycle");
	branch_two_cyc_a: assert property (
		(exec_end && (grp == GRP_UBRANCH || grp == GRP_CALL)) |=>
		(state_q.st == ST_EXTRA) [*4] ##1 (state_q.st == ST_EXEC && state_q.ph == 2'h0))
		else $error("branch or call did not take exactly two cycles");
	pcl_extra_cyc_a: assert property (
		(exec_end && wr_m && is_pcl(state_q.dm_addr) && !skip) |=> state_q.st == ST_EXTRA)
		else $error("low counter byte write took no extra cycle");
	pcl_jump_a: assert property (
		(exec_end && wr_m && is_pcl(state_q.dm_addr)) |=>
		(state_q.pc[7:0] == state_q.dm_wdata && pm_addr_o == state_q.pc))
		else $error("low counter byte write did not jump");
	skip_taken_a: assert property (
		(exec_end && skip) |=> (state_q.pc == $past(pc_inc) + PC_W'(1) &&
		state_q.st == ST_EXTRA) ##4 (state_q.st == ST_EXEC && state_q.ph == 2'h0))
		else $error("taken skip wrong target or length");
	subexit_target_a: assert property (
		(exec_end && grp == GRP_MISC && misc == MISC_SUBEXIT) |=>
		state_q.pc == $past(stk_bus.top))
		else $error("subroutine exit went to wrong address");
	xfer_imm_a: assert property (
		(exec_end && grp == GRP_XFER_AX) |=> state_q.acc == $past(opnd))
		else $error("immediate transfer did not load accumulator");
	add_carry_a: assert property (
		(exec_end && grp == GRP_ALU_X && sub == 3'h0) |=> state_q.c == $past(add_ovf))
		else $error("add carry wrong");
	bit_set_a: assert property (
		(exec_end && grp == GRP_BSET) |=>
		(dm_we_o && dm_wdata_o == ($past(mval) | bit_mask($past(sub)))))
		else $error("bit set changed other bits");
	pdown_enter_a: assert property (
		(exec_end && grp == GRP_MISC && misc == MISC_PDOWN) |=> (pdn_o && !icyc_done_o))
		else $error("power-down not entered");
	intexit_gie_a: assert property (
		(exec_end && grp == GRP_MISC && misc == MISC_INTEXIT) |=> gie_o)
		else $error("interrupt exit left interrupts disabled");

	call_seen_c: cover property (exec_end && grp == GRP_CALL);
	table_read_c: cover property (exec_end && grp == GRP_MISC && misc == MISC_TABRD);
	skip_seen_c: cover property (exec_end && skip);
	wake_seen_c: cover property (pdn_o ##1 !pdn_o);
endmodule

/* File: dv/mctc_mem.sv */
// Program and data memory model facing the instruction timing core
// Synchronous reads one clock after the address; the bench preloads both arrays
`timescale 1ns/100ps
module mctc_mem (
	input wire logic clock_i, // Core clock
	input wire logic [11:0] pm_addr_i, // Program address
	output logic [15:0] pm_data_o, // Program word
	input wire logic [7:0] dm_addr_i, // Data address
	input wire logic [7:0] dm_wdata_i, // Write data
	input wire logic dm_we_i, // Write strobe
	output logic [7:0] dm_rdata_o // Read data
);
	logic [15:0] pm [0:4095];
	logic [7:0] dm [0:255];
	always @(posedge clock_i) begin
		pm_data_o <= pm[pm_addr_i];
		dm_rdata_o <= dm[dm_addr_i];
		if (dm_we_i) begin
			dm[dm_addr_i] <= dm_wdata_i;
		end
	end
endmodule

/* File: dv/mctc_core_tb.sv */
// Self-checking bench for the instruction timing core
// Inputs change on falling edges; program and data come from the memory model
`timescale 1ns/100ps
module mctc_core_tb;
	logic clock_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic wake_i = 1'b0;
	logic [11:0] pm_addr;
	logic [15:0] pm_data;
	logic [7:0] dm_addr;
	logic [7:0] dm_rdata;
	logic [7:0] dm_wdata;
	logic dm_we;
	logic [11:0] pc;
	logic [7:0] acc;
	logic zero;
	logic carry;
	logic gie;
	logic pdn;
	logic done;
	int bad_count = 0;
	int total_checks = 0;
	int gap;
	always #2 clock_i = ~clock_i;
	mctc_core u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .pm_addr_o(pm_addr),
		.pm_data_i(pm_data), .dm_addr_o(dm_addr), .dm_rdata_i(dm_rdata),
		.dm_wdata_o(dm_wdata), .dm_we_o(dm_we), .wake_i(wake_i), .pc_o(pc),
		.acc_o(acc), .zero_o(zero), .carry_o(carry), .gie_o(gie), .pdn_o(pdn),
		.icyc_done_o(done));
	mctc_mem u_mem (.clock_i(clock_i), .pm_addr_i(pm_addr), .pm_data_o(pm_data),
		.dm_addr_i(dm_addr), .dm_wdata_i(dm_wdata), .dm_we_i(dm_we),
		.dm_rdata_o(dm_rdata));
	task automatic final_report();
		if (bad_count == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	// Clocks from the previous instruction end to the next one, bounded
	task automatic step();
		gap = 0;
		do begin
			@(negedge clock_i);
			gap++;
		end while (done !== 1'b1 && gap < 100);
	endtask
	task automatic ex(input logic [15:0] len, input logic [7:0] a, input logic z,
		input logic c);
		step();
		chk(16'(gap), len, "instruction length");
		chk(16'(acc), 16'(a), "accumulator");
		chk(16'({zero, carry}), 16'({z, c}), "flags");
	endtask
	// Holds the core in reset while the memories are wiped
	task automatic clr();
		rst_n_i = 1'b0;
		for (int i = 0; i < 4096; i++) begin
			u_mem.pm[i] = 16'h0000;
		end
		for (int i = 0; i < 256; i++) begin
			u_mem.dm[i] = 8'h00;
		end
	endtask
	// Releases reset and lets the no-operation at address zero finish
	task automatic go();
		repeat (4) @(negedge clock_i);
		rst_n_i = 1'b1;
		step();
	endtask
	task automatic t_branch();
		clr();
		u_mem.pm[8'h01] = 16'h3005;
		u_mem.pm[8'h02] = 16'hC010;
		go();
		ex(16'h4, 8'h05, 1'b0, 1'b0);
		ex(16'h8, 8'h05, 1'b0, 1'b0);
		ex(16'h4, 8'h05, 1'b0, 1'b0);
		chk(16'(pc), 16'h11, "branch target");
	endtask
	task automatic t_call();
		clr();
		u_mem.pm[8'h01] = 16'hD020;
		u_mem.pm[8'h02] = 16'hD030;
		u_mem.pm[8'h20] = 16'h0100;
		u_mem.pm[8'h30] = 16'h0200;
		go();
		ex(16'h8, 8'h00, 1'b0, 1'b0);
		ex(16'h8, 8'h00, 1'b0, 1'b0);
		chk(16'(pc), 16'h2, "return point");
		chk(16'(gie), 16'h0, "enable after plain exit");
		ex(16'h8, 8'h00, 1'b0, 1'b0);
		ex(16'h8, 8'h00, 1'b0, 1'b0);
		chk(16'(pc), 16'h3, "interrupt return point");
		chk(16'(gie), 16'h1, "enable after interrupt exit");
	endtask
	task automatic t_alu();
		clr();
		u_mem.dm[8'h10] = 8'hF0;
		u_mem.pm[8'h01] = 16'h3020;
		u_mem.pm[8'h02] = 16'h4010;
		u_mem.pm[8'h03] = 16'h5410;
		u_mem.pm[8'h04] = 16'h5401;
		u_mem.pm[8'h05] = 16'h5800;
		u_mem.pm[8'h06] = 16'h5CFF;
		u_mem.pm[8'h07] = 16'h4E10;
		u_mem.pm[8'h08] = 16'h5A30;
		u_mem.pm[8'h09] = 16'h50C1;
		u_mem.pm[8'h0A] = 16'h4210;
		u_mem.pm[8'h0B] = 16'h56F1;
		u_mem.pm[8'h0C] = 16'h4110;
		u_mem.pm[8'h0D] = 16'h1010;
		go();
		ex(16'h4, 8'h20, 1'b0, 1'b0);
		ex(16'h4, 8'h10, 1'b0, 1'b1);
		ex(16'h4, 8'h00, 1'b1, 1'b1);
		ex(16'h4, 8'hFF, 1'b0, 1'b0);
		ex(16'h4, 8'h00, 1'b1, 1'b0);
		ex(16'h4, 8'hFF, 1'b0, 1'b0);
		ex(16'h4, 8'h0F, 1'b0, 1'b0);
		ex(16'h4, 8'h3F, 1'b0, 1'b0);
		ex(16'h4, 8'h00, 1'b1, 1'b1);
		ex(16'h4, 8'hF1, 1'b0, 1'b0);
		ex(16'h4, 8'hFF, 1'b0, 1'b0);
		ex(16'h4, 8'hFF, 1'b0, 1'b1);
		ex(16'h4, 8'hEF, 1'b0, 1'b1);
	endtask
	task automatic t_unary();
		clr();
		u_mem.dm[8'h11] = 8'h81;
		u_mem.pm[8'h01] = 16'h6111;
		u_mem.pm[8'h02] = 16'h6211;
		u_mem.pm[8'h03] = 16'h6B11;
		u_mem.pm[8'h04] = 16'h6811;
		u_mem.pm[8'h05] = 16'h6611;
		u_mem.pm[8'h06] = 16'h6411;
		u_mem.pm[8'h07] = 16'h7A11;
		u_mem.pm[8'h08] = 16'h8411;
		u_mem.pm[8'h09] = 16'h1011;
		u_mem.pm[8'h0A] = 16'h2012;
		go();
		ex(16'h4, 8'h00, 1'b0, 1'b0);
		ex(16'h4, 8'h81, 1'b0, 1'b0);
		ex(16'h4, 8'h81, 1'b0, 1'b1);
		ex(16'h4, 8'h82, 1'b0, 1'b0);
		ex(16'h4, 8'h08, 1'b0, 1'b0);
		ex(16'h4, 8'h02, 1'b0, 1'b0);
		ex(16'h4, 8'h02, 1'b0, 1'b0);
		ex(16'h4, 8'h02, 1'b0, 1'b0);
		ex(16'h4, 8'h20, 1'b0, 1'b0);
		ex(16'h4, 8'h20, 1'b0, 1'b0);
		step();
		chk(16'(u_mem.dm[8'h12]), 16'h20, "stored byte");
	endtask
	task automatic t_skip();
		clr();
		u_mem.pm[8'h01] = 16'h9013;
		u_mem.pm[8'h02] = 16'h30AA;
		u_mem.pm[8'h03] = 16'hA013;
		u_mem.pm[8'h04] = 16'h3055;
		u_mem.pm[8'h05] = 16'hB013;
		u_mem.pm[8'h06] = 16'h3011;
		u_mem.pm[8'h07] = 16'h9113;
		u_mem.pm[8'h08] = 16'h3022;
		u_mem.pm[8'h09] = 16'h7013;
		u_mem.pm[8'h0A] = 16'hA013;
		u_mem.pm[8'h0B] = 16'h3099;
		u_mem.pm[8'h0C] = 16'h3066;
		go();
		ex(16'h8, 8'h00, 1'b0, 1'b0);
		ex(16'h4, 8'h00, 1'b0, 1'b0);
		ex(16'h4, 8'h55, 1'b0, 1'b0);
		ex(16'h8, 8'h55, 1'b0, 1'b0);
		ex(16'h4, 8'h55, 1'b0, 1'b0);
		ex(16'h4, 8'h22, 1'b0, 1'b0);
		ex(16'h4, 8'h22, 1'b0, 1'b0);
		ex(16'h8, 8'h22, 1'b0, 1'b0);
		ex(16'h4, 8'h66, 1'b0, 1'b0);
	endtask
	task automatic t_pcl();
		clr();
		u_mem.pm[8'h01] = 16'h3008;
		u_mem.pm[8'h02] = 16'h2006;
		u_mem.pm[8'h03] = 16'h3077;
		go();
		ex(16'h4, 8'h08, 1'b0, 1'b0);
		ex(16'h8, 8'h08, 1'b0, 1'b0);
		ex(16'h4, 8'h08, 1'b0, 1'b0);
		chk(16'(pc), 16'h9, "jump by low byte");
	endtask
	task automatic t_table();
		clr();
		u_mem.pm[8'h01] = 16'h3040;
		u_mem.pm[8'h02] = 16'h0400;
		u_mem.pm[8'h40] = 16'h12C3;
		go();
		ex(16'h4, 8'h40, 1'b0, 1'b0);
		ex(16'h8, 8'hC3, 1'b0, 1'b0);
		ex(16'h4, 8'hC3, 1'b0, 1'b0);
		chk(16'(pc), 16'h4, "after table");
	endtask
	task automatic t_pdown();
		clr();
		u_mem.pm[8'h01] = 16'h0300;
		u_mem.pm[8'h02] = 16'h3033;
		go();
		repeat (12) @(negedge clock_i);
		chk(16'(pdn), 16'h1, "asleep");
		chk(16'(pc), 16'h2, "halted pc");
		wake_i = 1'b1;
		step();
		wake_i = 1'b0;
		chk(16'(acc), 16'h33, "resumed");
		chk(16'(pdn), 16'h0, "awake");
	endtask
	initial begin
		t_branch();
		t_call();
		t_alu();
		t_unary();
		t_skip();
		t_pcl();
		t_table();
		t_pdown();
		final_report();
	end
	initial begin
		#40000;
		bad_count++;
		final_report();
	end
endmodule
